// >>> logic/swp_regs.vh
// constants for the scan-area parameter list parser
`ifndef SWP_REGS_VH
`define SWP_REGS_VH

// ****************************************
// list layout, absolute byte index
// ****************************************
`define SWP_LIST_BYTES   6'd48
`define SWP_HDR_RSV_LAST 6'd5
`define SWP_HDR_LEN_MSB  6'd6
`define SWP_HDR_LEN_LSB  6'd7
`define SWP_D_WINDOW_ID  6'd8
`define SWP_D_RSV1       6'd9
`define SWP_D_XRES       6'd10
`define SWP_D_YRES       6'd12
`define SWP_D_UL_X       6'd14
`define SWP_D_UL_Y       6'd18
`define SWP_D_WIDTH      6'd22
`define SWP_D_LENGTH     6'd26
`define SWP_D_BRIGHT     6'd30
`define SWP_D_THRESH     6'd31
`define SWP_D_CONTRAST   6'd32
`define SWP_D_COMPOSE    6'd33
`define SWP_D_BPP        6'd34
`define SWP_D_HALFTONE   6'd35
`define SWP_D_PADDING    6'd37
`define SWP_D_SCAN_DIR   6'd38
`define SWP_D_COMP_TYPE  6'd40
`define SWP_D_COMP_ARG   6'd41

// ****************************************
// values, limits and defaults
// ****************************************
`define SWP_DESC_LEN     16'd40
`define SWP_WINDOW_ID    8'h00
`define SWP_RES_MIN      16'd72
`define SWP_RES_MAX      16'd300
`define SWP_RES_DEF      16'd72
`define SWP_UL_DEF       32'd0
`define SWP_WIDTH_DEF    32'd10200
`define SWP_LENGTH_DEF   32'd13200
`define SWP_BRIGHT_DEF   8'd128
`define SWP_THRESH_DEF   8'd128
`define SWP_CONTRAST_DEF 8'd128
`define SWP_COMP_LINEART 8'h00
`define SWP_COMP_HALFTON 8'h01
`define SWP_COMP_GRAY    8'h02
`define SWP_BPP_16LVL    8'h04
`define SWP_BPP_256LVL   8'h08
`define SWP_PAD_TRUNC    8'h03
`define SWP_ALIGN_UNIT   48'd9600

`endif

// >>> logic/swp_align_chk.v
// byte-boundary check of a coordinate at a given resolution
`timescale 1ns/1ps
`default_nettype none
`include "swp_regs.vh"

module swp_align_chk (
  input  wire [31:0] coord,
  input  wire [15:0] res,
  output wire        aligned
);
  // pixels = coord*res/1200; a whole byte of pixels needs a multiple of 8
  wire [47:0] prod;
  assign prod    = {16'h0000, coord} * {32'h00000000, res};
  assign aligned = ((prod % `SWP_ALIGN_UNIT) == 48'h000000000000);
endmodule

`default_nettype wire

// >>> logic/swp_parser.v
// scan-area parameter list parser, checker and settings latch
// Function
// - one 8-byte header and exactly one 40-byte descriptor accepted.
// - header bytes 6-7 big-endian hold descriptor length, always 40.
// - descriptor byte 0 is window id; only zero is valid.
// - horizontal resolution bytes 2-3, accepted 72 to 300 dpi.
// - zero horizontal resolution means 72 dpi.
// - vertical resolution bytes 4-5, accepted 72 to 300 dpi.
// - zero vertical resolution means 72 dpi.
// - bytes 6-9 hold upper-left x in 1/1200 inch.
// - upper-left coordinates default to zero.
// - bytes 10-13 hold upper-left y in 1/1200 inch.
// - zero width means 10,200.
// - bytes 18-21 hold length; zero length means 13,200.
// - composition 0 line art, 1 halftone, 2 grayscale; line art default.
// - grayscale gives 16 levels at 4 bpp, 256 levels at 8 bpp.
// - zero brightness means 128; otherwise relative to 128.
// - padding type must be 3; partial bytes truncated.
`timescale 1ns/1ps
`default_nettype none
`include "swp_regs.vh"

module swp_parser (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        list_start,
  input  wire        byte_valid,
  input  wire [7:0]  byte_data,
  input  wire        list_end,
  output reg         busy,
  output reg         cfg_valid,
  output reg         param_error,
  output reg         err_count,
  output reg         err_length,
  output reg         err_window,
  output reg         err_res,
  output reg         err_align,
  output reg         err_padding,
  output reg  [15:0] x_res,
  output reg  [15:0] y_res,
  output reg  [31:0] ul_x,
  output reg  [31:0] ul_y,
  output reg  [31:0] win_width,
  output reg  [31:0] win_length,
  output reg  [7:0]  brightness,
  output reg  [7:0]  threshold,
  output reg  [7:0]  contrast,
  output reg  [7:0]  composition,
  output reg  [7:0]  bits_per_pixel,
  output reg  [15:0] halftone,
  output reg  [15:0] scan_dir,
  output reg  [7:0]  compress_type,
  output reg  [7:0]  compress_arg,
  output reg         gray_256,
  output reg         pad_truncate
);

  // ****************************************
  // states
  // ****************************************
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_RECV  = 3'b010;
  localparam [2:0] ST_CHECK = 3'b100;

  reg [2:0] state;
  reg [5:0] byte_cnt;
  reg       overrun;
  reg [7:0] list_mem [0:47];

  // ****************************************
  // field access
  // ****************************************
  function [15:0] be16;
    input [5:0] idx;
    begin
      be16 = {list_mem[idx], list_mem[idx + 6'd1]};
    end
  endfunction

  function [31:0] be32;
    input [5:0] idx;
    begin
      be32 = {list_mem[idx], list_mem[idx + 6'd1],
              list_mem[idx + 6'd2], list_mem[idx + 6'd3]};
    end
  endfunction

  function res_ok;
    input [15:0] r;
    begin
      res_ok = (r == 16'h0000) ||
               ((r >= `SWP_RES_MIN) && (r <= `SWP_RES_MAX));
    end
  endfunction

  function [15:0] res_eff;
    input [15:0] r;
    begin
      res_eff = (r == 16'h0000) ? `SWP_RES_DEF : r;
    end
  endfunction

  function [31:0] or_def32;
    input [31:0] v;
    input [31:0] d;
    begin
      or_def32 = (v == 32'h00000000) ? d : v;
    end
  endfunction

  function [7:0] or_def8;
    input [7:0] v;
    input [7:0] d;
    begin
      or_def8 = (v == 8'h00) ? d : v;
    end
  endfunction

  // ****************************************
  // checks on the captured list
  // ****************************************
  wire [15:0] raw_xres;
  wire [15:0] raw_yres;
  wire [15:0] eff_xres;
  wire [15:0] eff_yres;
  wire [31:0] raw_ulx;
  wire [31:0] raw_width;
  wire [31:0] eff_width;
  wire        ulx_aligned;
  wire        width_aligned;
  wire        bad_count;
  wire        bad_length;
  wire        bad_window;
  wire        bad_res;
  wire        bad_align;
  wire        bad_padding;
  wire        any_bad;

  assign raw_xres  = be16(`SWP_D_XRES);
  assign raw_yres  = be16(`SWP_D_YRES);
  assign eff_xres  = res_eff(raw_xres);
  assign eff_yres  = res_eff(raw_yres);
  assign raw_ulx   = be32(`SWP_D_UL_X);
  assign raw_width = be32(`SWP_D_WIDTH);
  assign eff_width = or_def32(raw_width, `SWP_WIDTH_DEF);

  swp_align_chk u_ulx_chk (
    .coord   (raw_ulx),
    .res     (eff_xres),
    .aligned (ulx_aligned)
  );

  swp_align_chk u_width_chk (
    .coord   (eff_width),
    .res     (eff_xres),
    .aligned (width_aligned)
  );

  // a short list or extra bytes break the one-header-one-descriptor shape
  assign bad_count   = overrun || (byte_cnt != `SWP_LIST_BYTES);
  assign bad_length  = be16(`SWP_HDR_LEN_MSB) != `SWP_DESC_LEN;
  assign bad_window  = list_mem[`SWP_D_WINDOW_ID] != `SWP_WINDOW_ID;
  assign bad_res     = !res_ok(raw_xres) || !res_ok(raw_yres);
  assign bad_align   = !ulx_aligned || !width_aligned;
  assign bad_padding = list_mem[`SWP_D_PADDING] != `SWP_PAD_TRUNC;
  assign any_bad     = bad_count || bad_length || bad_window ||
                       bad_res || bad_align || bad_padding;

  // ****************************************
  // byte capture
  // ****************************************
  always @(posedge ref_clk) begin
    // a byte past the last slot only flags overrun, it is never stored
    if (!rst && (state == ST_RECV) && byte_valid && !overrun &&
        (byte_cnt != `SWP_LIST_BYTES)) begin
      list_mem[byte_cnt] <= byte_data;
    end
  end

  // ****************************************
  // sequencing and settings latch
  // ****************************************
  always @(posedge ref_clk) begin
    if (rst) begin
      state          <= ST_IDLE;
      byte_cnt       <= 6'd0;
      overrun        <= 1'b0;
      busy           <= 1'b0;
      cfg_valid      <= 1'b0;
      param_error    <= 1'b0;
      err_count      <= 1'b0;
      err_length     <= 1'b0;
      err_window     <= 1'b0;
      err_res        <= 1'b0;
      err_align      <= 1'b0;
      err_padding    <= 1'b0;
      x_res          <= `SWP_RES_DEF;
      y_res          <= `SWP_RES_DEF;
      ul_x           <= `SWP_UL_DEF;
      ul_y           <= `SWP_UL_DEF;
      win_width      <= `SWP_WIDTH_DEF;
      win_length     <= `SWP_LENGTH_DEF;
      brightness     <= `SWP_BRIGHT_DEF;
      threshold      <= `SWP_THRESH_DEF;
      contrast       <= `SWP_CONTRAST_DEF;
      composition    <= `SWP_COMP_LINEART;
      bits_per_pixel <= 8'h00;
      halftone       <= 16'h0000;
      scan_dir       <= 16'h0000;
      compress_type  <= 8'h00;
      compress_arg   <= 8'h00;
      gray_256       <= 1'b0;
      pad_truncate   <= 1'b1;
    end else begin
      cfg_valid   <= 1'b0;
      param_error <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (list_start) begin
            state    <= ST_RECV;
            byte_cnt <= 6'd0;
            overrun  <= 1'b0;
            busy     <= 1'b1;
          end
        end
        ST_RECV: begin
          if (byte_valid) begin
            if (byte_cnt == `SWP_LIST_BYTES) begin
              overrun <= 1'b1;
            end else begin
              byte_cnt <= byte_cnt + 6'd1;
            end
          end
          if (list_end) begin
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          state       <= ST_IDLE;
          busy        <= 1'b0;
          err_count   <= bad_count;
          err_length  <= bad_length;
          err_window  <= bad_window;
          err_res     <= bad_res;
          err_align   <= bad_align;
          err_padding <= bad_padding;
          // a rejected list leaves the previous settings in force
          if (any_bad) begin
            param_error <= 1'b1;
          end else begin
            cfg_valid      <= 1'b1;
            x_res          <= eff_xres;
            y_res          <= eff_yres;
            ul_x           <= raw_ulx;
            ul_y           <= be32(`SWP_D_UL_Y);
            win_width      <= eff_width;
            win_length     <= or_def32(be32(`SWP_D_LENGTH),
                                       `SWP_LENGTH_DEF);
            brightness     <= or_def8(list_mem[`SWP_D_BRIGHT],
                                      `SWP_BRIGHT_DEF);
            threshold      <= or_def8(list_mem[`SWP_D_THRESH],
                                      `SWP_THRESH_DEF);
            contrast       <= or_def8(list_mem[`SWP_D_CONTRAST],
                                      `SWP_CONTRAST_DEF);
            composition    <= list_mem[`SWP_D_COMPOSE];
            bits_per_pixel <= list_mem[`SWP_D_BPP];
            halftone       <= be16(`SWP_D_HALFTONE);
            scan_dir       <= be16(`SWP_D_SCAN_DIR);
            compress_type  <= list_mem[`SWP_D_COMP_TYPE];
            compress_arg   <= list_mem[`SWP_D_COMP_ARG];
            gray_256       <= (list_mem[`SWP_D_COMPOSE] == `SWP_COMP_GRAY)
                              && (list_mem[`SWP_D_BPP]
                                  == `SWP_BPP_256LVL);
            pad_truncate   <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> test/swp_parser_sva.sv
// port assertions for the scan-area parameter list parser
`timescale 1ns/1ps
`default_nettype none
module swp_parser_sva (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        list_start,
  input wire logic        list_end,
  input wire logic        busy,
  input wire logic        cfg_valid,
  input wire logic        param_error,
  input wire logic        err_count,
  input wire logic        err_length,
  input wire logic        err_window,
  input wire logic        err_res,
  input wire logic        err_align,
  input wire logic        err_padding,
  input wire logic [15:0] x_res,
  input wire logic [15:0] y_res,
  input wire logic [7:0]  composition,
  input wire logic [7:0]  bits_per_pixel,
  input wire logic        gray_256,
  input wire logic        pad_truncate
);
  // ************
  // checks
  // ************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic done = cfg_valid | param_error;
  wire logic bad  = |{err_count, err_length, err_window,
                      err_res, err_align, err_padding};

  a_end_lat: assert property (busy && list_end |=> !done ##1 done)
    else $error("verdict not two edges after list end");
  a_one_verdict: assert property (!(cfg_valid && param_error))
    else $error("accept and reject together");
  a_start_busy: assert property (!busy && list_start |=> busy)
    else $error("list start not taken");
  a_idle_done: assert property (done |-> !busy)
    else $error("busy during verdict");
  a_err_cause: assert property (param_error |-> bad)
    else $error("reject without cause");
  a_ok_clean: assert property (cfg_valid |-> !bad)
    else $error("accept with cause flag");
  a_res_range: assert property (cfg_valid |->
    x_res inside {[16'h48:16'h12c]} && y_res inside {[16'h48:16'h12c]})
    else $error("resolution out of range");
  a_reject_keep: assert property (param_error |->
    $stable(x_res) && $stable(y_res))
    else $error("settings changed on reject");
  a_gray_mode: assert property (gray_256 ==
    (composition == 8'h02 && bits_per_pixel == 8'h08))
    else $error("grey level mode wrong");
  a_pad_trunc: assert property (pad_truncate)
    else $error("padding not truncating");

  c_accept: cover property (cfg_valid);
  c_res_bad: cover property (param_error && err_res);
  c_align_bad: cover property (param_error && err_align);
  c_gray: cover property (gray_256);
endmodule

bind swp_parser swp_parser_sva u_sva (.*);
`default_nettype wire

// >>> test/swp_host.sv
// host initiator model sending one parameter list byte by byte
`timescale 1ns/1ps
`default_nettype none
module swp_host (
  input  wire logic             ref_clk,
  input  wire logic [0:47][7:0] lst,
  output var logic              list_start = 1'b0,
  output var logic              byte_valid = 1'b0,
  output var logic [7:0]        byte_data  = 8'h00,
  output var logic              list_end   = 1'b0
);
  // ************
  // list transfer
  // ************
  // slow leaves an idle cycle after each byte; idle data is inverted
  // so a parser that takes a stale byte shows it
  task send(input int n, input bit slow);
    @(negedge ref_clk);
    list_start <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      list_start <= 1'b0;
      byte_valid <= 1'b1;
      byte_data  <= lst[i % 48];
      list_end   <= (i == n - 1);
      if (slow && i < n - 1) begin
        @(negedge ref_clk);
        byte_valid <= 1'b0;
        byte_data  <= ~lst[i % 48];
      end
    end
    @(negedge ref_clk);
    byte_valid <= 1'b0;
    list_end   <= 1'b0;
    byte_data  <= ~byte_data;
  endtask
endmodule
`default_nettype wire

// >>> test/tb_swp_parser.sv
// self-checking bench for the scan-area parameter list parser
`timescale 1ns/1ps
`default_nettype none
module tb_swp_parser;
  typedef struct packed {
    logic [15:0] xr, yr, hl;
    logic [31:0] ux, w;
    logic [7:0]  id, pad, e;
  } swp_row_t;
  logic             ref_clk, rst, list_start, byte_valid, list_end, busy;
  logic             cfg_valid, param_error, gray_256, pad_truncate;
  logic             err_count, err_length, err_window, err_res;
  logic             err_align, err_padding;
  logic [4:0]       ke;
  logic [7:0]       byte_data, brightness, threshold, contrast;
  logic [7:0]       composition, bits_per_pixel, compress_type;
  logic [7:0]       compress_arg;
  logic [15:0]      x_res, y_res, halftone, scan_dir, kx, ky;
  logic [31:0]      ul_x, ul_y, win_width, win_length, kw;
  logic [0:47][7:0] lst;
  swp_row_t         rows [0:9];
  int               num_errors = 0;
  int               n_tests = 0;

  swp_parser u_dut (.*);
  swp_host   u_host (.*);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ************
  // helpers
  // ************
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      $display("Error %s expected %h seen %h", s, x, g);
      num_errors++;
    end
  endtask

  task put(input int at, input int nb, input logic [31:0] v);
    for (int k = 0; k < nb; k++)
      lst[at + k] = v[8 * (nb - 1 - k) +: 8];
  endtask

  task run(input int n, input bit slow);
    u_host.send(n, slow);
    repeat (8)
      if (cfg_valid !== 1'b1 && param_error !== 1'b1)
        @(negedge ref_clk);
  endtask

  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // a run takes about 1200 cycles
  initial begin
    repeat (4000) @(posedge ref_clk);
    num_errors++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    lst = '0;
    rows[0] = '{16'h48, 16'h48, 16'h28, 32'h0, 32'h320, 8'h0, 8'h3, 8'h0};
    rows[1] = '{16'h0, 16'h0, 16'h28, 32'h190, 32'h320, 8'h0, 8'h3, 8'h0};
    rows[2] = '{16'h60, 16'h64, 16'h28, 32'h0, 32'h0, 8'h0, 8'h3, 8'h0};
    rows[3] = '{16'h47, 16'h48, 16'h28, 32'h0, 32'h2580, 8'h0, 8'h3, 8'h4};
    rows[4] = '{16'h12c, 16'h12d, 16'h28, 32'h20, 32'h400, 8'h0, 8'h3, 8'h4};
    rows[5] = '{16'h12c, 16'h12c, 16'h28, 32'h10, 32'h400, 8'h0, 8'h3, 8'h2};
    rows[6] = '{16'h12c, 16'h12c, 16'h28, 32'h20, 32'h400, 8'h1, 8'h3, 8'h8};
    rows[7] = '{16'h12c, 16'h12c, 16'h28, 32'h20, 32'h400, 8'h0, 8'h0, 8'h1};
    rows[8] = '{16'h12c, 16'h12c, 16'h29, 32'h20, 32'h400, 8'h0, 8'h3, 8'h10};
    rows[9] = '{16'h12c, 16'h12c, 16'h28, 32'h20, 32'h400, 8'h0, 8'h3, 8'h0};
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    kx = 16'h48;
    chk("res", 32'h480048, {x_res, y_res});
    chk("ul_x", 32'h0, ul_x);
    chk("win_width", 32'h27d8, win_width);
    chk("win_length", 32'h3390, win_length);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      put(6, 2, rows[i].hl);
      put(8, 1, rows[i].id);
      put(10, 4, {rows[i].xr, rows[i].yr});
      put(14, 4, rows[i].ux);
      put(22, 4, rows[i].w);
      put(37, 1, rows[i].pad);
      run(48, i[0]);
      ke = {err_length, err_window, err_res, err_align, err_padding};
      chk("causes", rows[i].e, {err_count, ke});
      chk("busy", 1'b0, busy);
      if (rows[i].e == 8'h0) begin
        kx = rows[i].xr == 16'h0 ? 16'h48 : rows[i].xr;
        ky = rows[i].yr == 16'h0 ? 16'h48 : rows[i].yr;
        kw = rows[i].w == 32'h0 ? 32'h27d8 : rows[i].w;
        chk("cfg_valid", 1'b1, cfg_valid);
        chk("res", {kx, ky}, {x_res, y_res});
        chk("ul_x", rows[i].ux, ul_x);
        chk("win_width", kw, win_width);
      end else begin
        chk("param_error", 1'b1, param_error);
        chk("x_res kept", kx, x_res);
      end
      $display("test row %0d done", i);
    end
    put(31, 1, 8'h11);
    put(33, 2, 16'h0208);
    put(35, 2, 16'h0102);
    put(38, 4, 32'h0304a5c3);
    put(18, 4, 32'h1234);
    put(26, 4, 32'h2000);
    run(48, 1'b1);
    chk("brightness", 8'h80, brightness);
    chk("threshold", 8'h11, threshold);
    chk("halftone", 16'h0102, halftone);
    chk("scan_dir", 16'h0304, scan_dir);
    chk("compress", 16'ha5c3, {compress_type, compress_arg});
    chk("ul_y", 32'h1234, ul_y);
    chk("gray_256", 1'b1, gray_256);
    chk("contrast", 8'h80, contrast);
    chk("win_length", 32'h2000, win_length);
    chk("bits_per_pixel", 8'h08, bits_per_pixel);
    chk("composition", 8'h02, composition);
    chk("pad_truncate", 1'b1, pad_truncate);
    for (int i = 0; i < 3; i++) begin
      put(30, 1, i + 1);
      put(33, 2, {i[7:0], 8'h04});
      run(48, 1'b0);
      chk("composition", i, composition);
      chk("brightness", i + 1, brightness);
      chk("gray_256", 1'b0, gray_256);
    end
    $display("test fields done");
    run(47, 1'b0);
    chk("short", 2'b11, {param_error, err_count});
    run(49, 1'b1);
    chk("overrun", 2'b11, {param_error, err_count});
    $display("test count done");
    // reset cuts a list in mid-flight; the rest of it must be ignored
    fork
      u_host.send(48, 1'b0);
    join_none
    repeat (10) @(negedge ref_clk);
    rst = 1'b1;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    chk("busy", 1'b0, busy);
    chk("res", 32'h480048, {x_res, y_res});
    chk("composition", 8'h0, composition);
    wait fork;
    repeat (2) @(negedge ref_clk);
    chk("idle after cut", 3'b000, {busy, cfg_valid, param_error});
    chk("res", 32'h480048, {x_res, y_res});
    $display("test second reset done");
    stop_test();
  end
endmodule
`default_nettype wire
